// ==== logic/lasr_pkg.sv ====
// shared constants for the link alias and status register bank
package lasr_pkg;
	// =====================================================
	// register offsets
	localparam logic [7:0] LASR_OFF_ALIAS     = 8'h08;
	localparam logic [7:0] LASR_OFF_SETUP     = 8'h09;
	localparam logic [7:0] LASR_OFF_CRC_LOW   = 8'h0A;
	localparam logic [7:0] LASR_OFF_CRC_HIGH  = 8'h0B;
	localparam logic [7:0] LASR_OFF_STATUS    = 8'h0C;
	// =====================================================
	// reset values
	localparam logic [6:0] LASR_ALIAS_RESET   = 7'h00;
	localparam logic [3:0] LASR_SETUP_RESET   = 4'h1;
	localparam logic [15:0] LASR_CRC_RESET    = 16'h0000;
	// =====================================================
	// status bit positions
	localparam int LASR_STS_DSI   = 6;
	localparam int LASR_STS_PHY   = 5;
	localparam int LASR_STS_LOST  = 4;
	localparam int LASR_STS_BIST  = 3;
	localparam int LASR_STS_PCLK  = 2;
	localparam int LASR_STS_DES   = 1;
	localparam int LASR_STS_LINK  = 0;
	// =====================================================
	// ack setup timing at 50 MHz
	localparam int LASR_CLK_MHZ        = 50;
	localparam int LASR_SETUP_BASE_NS  = 80;
	localparam int LASR_SETUP_STEP_NS  = 640;
	localparam int LASR_SETUP_BASE_CYC = (LASR_SETUP_BASE_NS * LASR_CLK_MHZ + 999) / 1000;
	localparam int LASR_SETUP_STEP_CYC = (LASR_SETUP_STEP_NS * LASR_CLK_MHZ + 999) / 1000;
	localparam int LASR_SETUP_CNT_W    = 10;
endpackage

// ==== logic/lasr_port_status.sv ====
// per-port counter and sticky status flags
`timescale 1ns/100ps
module lasr_port_status (
	input  wire logic        core_clk,
	input  wire logic        rst,
	input  wire logic        crcResetReq,
	input  wire logic        backCrcErr,
	input  wire logic        linkLostEvt,
	input  wire logic        selftestCrcErr,
	input  wire logic        selftestRestart,
	input  wire logic        desCrcErr,
	output logic [15:0]      crcCount,
	output logic             linkLostFlag,
	output logic             selftestCrcFlag,
	output logic             desErrorFlag
);
	import lasr_pkg::*;

	// =====================================================
	// counter, saturates so a burst never wraps to a small value
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			crcCount <= LASR_CRC_RESET;
		end else if (crcResetReq) begin
			crcCount <= LASR_CRC_RESET;
		end else if (backCrcErr && crcCount != 16'hFFFF) begin
			crcCount <= crcCount + 16'h0001;
		end
	end

	// =====================================================
	// sticky flags; a set in the clear cycle wins
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			linkLostFlag <= 1'b0;
		end else if (linkLostEvt) begin
			linkLostFlag <= 1'b1;
		end else if (crcResetReq) begin
			linkLostFlag <= 1'b0;
		end
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			selftestCrcFlag <= 1'b0;
		end else if (selftestCrcErr) begin
			selftestCrcFlag <= 1'b1;
		end else if (selftestRestart || crcResetReq) begin
			selftestCrcFlag <= 1'b0;
		end
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			desErrorFlag <= 1'b0;
		end else if (desCrcErr) begin
			desErrorFlag <= 1'b1;
		end else if (linkLostEvt || crcResetReq) begin
			desErrorFlag <= 1'b0;
		end
	end
endmodule

// ==== logic/lasr_top.sv ====
// register bank: remote target alias, ack setup, crc counter, status
`timescale 1ns/100ps
module lasr_top (
	input  wire logic        core_clk,
	input  wire logic        rst,
	// register port from the local i2c target
	input  wire logic [7:0]  regAddr,
	input  wire logic [7:0]  regWrData,
	input  wire logic        regWrEn,
	input  wire logic        regRdEn,
	output logic [7:0]       regRdData,
	output logic             regHit,
	// controls held in other register groups
	input  wire logic        secondPortSelect,
	input  wire logic        crcErrorReset,
	input  wire logic [6:0]  remoteTargetAddress,
	input  wire logic [6:0]  remoteTargetAddressPort1,
	// incoming i2c address and forwarding
	input  wire logic        addrValid,
	input  wire logic [6:0]  addrIn,
	output logic             fwdValid,
	output logic             fwdPort1,
	output logic [6:0]       fwdAddr,
	// acknowledge cycle sda setup
	input  wire logic        remoteAccess,
	input  wire logic        ackSdaReq,
	output logic             ackSdaRelease,
	// error and status sources, from pins or other clocks
	input  wire logic [4:0]  dsiErrors,
	input  wire logic [1:0]  laneSyncError,
	input  wire logic [1:0]  laneFault,
	input  wire logic [1:0]  backCrcErr,
	input  wire logic [1:0]  linkLostEvt,
	input  wire logic [1:0]  selftestCrcErr,
	input  wire logic [1:0]  selftestRestart,
	input  wire logic [1:0]  desCrcErr,
	input  wire logic [1:0]  pclkMeetsThreshold,
	input  wire logic [1:0]  cableLinkDetected
);
	import lasr_pkg::*;

	localparam int NSRC = 21;

	// =====================================================
	// two-stage synchronisers for outside inputs
	logic [NSRC-1:0] srcRaw;
	logic [NSRC-1:0] srcMeta;
	logic [NSRC-1:0] srcSync;
	logic [NSRC-1:0] srcPrev;

	// cable link levels ride on their own synchroniser below
	assign srcRaw = {pclkMeetsThreshold, desCrcErr, selftestRestart,
		selftestCrcErr, linkLostEvt, backCrcErr, laneFault, laneSyncError, dsiErrors};

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			srcMeta <= '0;
			srcSync <= '0;
			srcPrev <= '0;
		end else begin
			srcMeta <= srcRaw;
			srcSync <= srcMeta;
			srcPrev <= srcSync;
		end
	end

	// events are rising edges of the synchronised levels
	logic [NSRC-1:0] srcRise;
	assign srcRise = srcSync & ~srcPrev;

	logic [4:0] dsiS;
	logic [1:0] syncErrS;
	logic [1:0] laneFaultS;
	logic [1:0] backCrcE;
	logic [1:0] lostE;
	logic [1:0] bistErrE;
	logic [1:0] bistRstE;
	logic [1:0] desErrE;
	logic [1:0] pclkS;
	logic [1:0] linkS;
	logic [1:0] linkMeta;
	logic [1:0] linkSyncPair;
	assign dsiS       = srcSync[4:0];
	assign syncErrS   = srcSync[6:5];
	assign laneFaultS = srcSync[8:7];
	assign backCrcE   = srcRise[10:9];
	assign lostE      = srcRise[12:11];
	assign bistErrE   = srcRise[14:13];
	assign bistRstE   = srcRise[16:15];
	assign desErrE    = srcRise[18:17];
	assign pclkS      = srcSync[20:19];
	assign linkS      = linkSyncPair;

	// =====================================================
	// cable link levels kept on their own synchroniser
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			linkMeta     <= 2'b00;
			linkSyncPair <= 2'b00;
		end else begin
			linkMeta     <= cableLinkDetected;
			linkSyncPair <= linkMeta;
		end
	end

	// =====================================================
	// crc reset request as a one-cycle pulse from its rising edge
	logic crcResetPrev_q;
	logic crcResetPulse;
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			crcResetPrev_q <= 1'b0;
		end else begin
			crcResetPrev_q <= crcErrorReset;
		end
	end
	assign crcResetPulse = crcErrorReset & ~crcResetPrev_q;

	// =====================================================
	// per-port alias registers and one shared setup register
	logic [6:0] aliasField_q [2];
	logic [3:0] setupField_q;
	logic       portIdx;
	assign portIdx = secondPortSelect;

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			aliasField_q[0] <= LASR_ALIAS_RESET;
			aliasField_q[1] <= LASR_ALIAS_RESET;
		end else if (regWrEn && regAddr == LASR_OFF_ALIAS) begin
			aliasField_q[portIdx] <= regWrData[7:1];
		end
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			setupField_q <= LASR_SETUP_RESET;
		end else if (regWrEn && regAddr == LASR_OFF_SETUP) begin
			setupField_q <= regWrData[3:0];
		end
	end

	// =====================================================
	// per-port counters and sticky flags
	logic [15:0] crcCount [2];
	logic [1:0]  lostFlag;
	logic [1:0]  bistFlag;
	logic [1:0]  desFlag;

	for (genvar p = 0; p < 2; p++) begin : g_port
		lasr_port_status u_status (
			.core_clk        (core_clk),
			.rst             (rst),
			.crcResetReq     (crcResetPulse),
			.backCrcErr      (backCrcE[p]),
			.linkLostEvt     (lostE[p]),
			.selftestCrcErr  (bistErrE[p]),
			.selftestRestart (bistRstE[p]),
			.desCrcErr       (desErrE[p]),
			.crcCount        (crcCount[p]),
			.linkLostFlag    (lostFlag[p]),
			.selftestCrcFlag (bistFlag[p]),
			.desErrorFlag    (desFlag[p])
		);
	end

	// =====================================================
	// status byte; levels and sticky flags, reads never clear them
	logic [7:0] statusByte;
	always_comb begin
		statusByte                = 8'h00;
		statusByte[LASR_STS_DSI]  = |dsiS;
		statusByte[LASR_STS_PHY]  = |syncErrS | |laneFaultS;
		statusByte[LASR_STS_LOST] = lostFlag[portIdx];
		statusByte[LASR_STS_BIST] = bistFlag[portIdx];
		statusByte[LASR_STS_PCLK] = pclkS[portIdx];
		statusByte[LASR_STS_DES]  = desFlag[portIdx];
		statusByte[LASR_STS_LINK] = linkS[portIdx];
	end

	// =====================================================
	// register read, one cycle after the read strobe
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			regRdData <= 8'h00;
			regHit    <= 1'b0;
		end else if (regRdEn) begin
			regHit <= 1'b1;
			case (regAddr)
				LASR_OFF_ALIAS:    regRdData <= {aliasField_q[portIdx], 1'b0};
				LASR_OFF_SETUP:    regRdData <= {4'h0, setupField_q};
				LASR_OFF_CRC_LOW:  regRdData <= crcCount[portIdx][7:0];
				LASR_OFF_CRC_HIGH: regRdData <= crcCount[portIdx][15:8];
				LASR_OFF_STATUS:   regRdData <= statusByte;
				default: begin
					regRdData <= 8'h00;
					regHit    <= 1'b0;
				end
			endcase
		end else begin
			regHit <= 1'b0;
		end
	end

	// =====================================================
	// alias decode and remap, one cycle latency
	logic [1:0] aliasMatch;
	always_comb begin
		for (int p = 0; p < 2; p++) begin
			// zero alias never matches, so the remote target is unreachable
			aliasMatch[p] = addrValid && aliasField_q[p] != 7'h00
				&& addrIn == aliasField_q[p];
		end
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			fwdValid <= 1'b0;
			fwdPort1 <= 1'b0;
			fwdAddr  <= 7'h00;
		end else begin
			fwdValid <= |aliasMatch;
			if (aliasMatch[0]) begin
				fwdPort1 <= 1'b0;
				fwdAddr  <= remoteTargetAddress;
			end else if (aliasMatch[1]) begin
				fwdPort1 <= 1'b1;
				fwdAddr  <= remoteTargetAddressPort1;
			end
		end
	end

	// =====================================================
	// ack setup delay: sda released this many cycles before scl rises
	logic [LASR_SETUP_CNT_W-1:0] setupCycles;
	logic [LASR_SETUP_CNT_W-1:0] setupCnt_q;
	assign setupCycles = LASR_SETUP_CNT_W'(LASR_SETUP_BASE_CYC)
		+ LASR_SETUP_CNT_W'(setupField_q * LASR_SETUP_STEP_CYC);

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			setupCnt_q    <= '0;
			ackSdaRelease <= 1'b0;
		end else if (!(remoteAccess && ackSdaReq)) begin
			setupCnt_q    <= '0;
			ackSdaRelease <= 1'b0;
		end else if (setupCnt_q + 1'b1 >= setupCycles) begin
			ackSdaRelease <= 1'b1;
		end else begin
			setupCnt_q <= setupCnt_q + 1'b1;
		end
	end
endmodule

// ==== sim/lasr_far_model.sv ====
// remote deserializer stand-in: raises link and crc events per port
`timescale 1ns/100ps
module lasr_far_model (
	input  wire logic       core_clk,
	input  wire logic       rst,
	input  wire logic       goEvt,
	input  wire logic [2:0] evtKind,
	input  wire logic       evtPort,
	output logic [1:0]      backCrcErr,
	output logic [1:0]      linkLostEvt,
	output logic [1:0]      desCrcErr,
	output logic [1:0]      selftestCrcErr,
	output logic [1:0]      selftestRestart
);
	logic [2:0] holdQ;
	logic [2:0] kindQ;
	logic       portQ;
	logic [9:0] evtLines;
	// level held 4 cycles so the two-flop synchroniser surely sees the edge
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			holdQ <= 3'h0;
			kindQ <= 3'h0;
			portQ <= 1'b0;
		end else if (goEvt) begin
			holdQ <= 3'h4;
			kindQ <= evtKind;
			portQ <= evtPort;
		end else if (holdQ != 3'h0) begin
			holdQ <= holdQ - 3'h1;
		end
	end
	assign evtLines = (holdQ != 3'h0) ? (10'h001 << {kindQ, portQ}) : 10'h000;
	assign {selftestRestart, selftestCrcErr, desCrcErr, linkLostEvt, backCrcErr} = evtLines;
endmodule

// ==== sim/lasr_properties.sv ====
// port checker for the link alias and status register bank
`timescale 1ns/100ps
module lasr_properties (
	input wire logic       core_clk,
	input wire logic       rst,
	input wire logic [7:0] regAddr,
	input wire logic [7:0] regWrData,
	input wire logic       regWrEn,
	input wire logic       regRdEn,
	input wire logic [7:0] regRdData,
	input wire logic       regHit,
	input wire logic       secondPortSelect,
	input wire logic [6:0] remoteTargetAddress,
	input wire logic [6:0] remoteTargetAddressPort1,
	input wire logic       addrValid,
	input wire logic [6:0] addrIn,
	input wire logic       fwdValid,
	input wire logic       fwdPort1,
	input wire logic [6:0] fwdAddr,
	input wire logic       remoteAccess,
	input wire logic       ackSdaReq,
	input wire logic       ackSdaRelease,
	input wire logic [4:0] dsiErrors,
	input wire logic [1:0] laneSyncError,
	input wire logic [1:0] laneFault,
	input wire logic [1:0] pclkMeetsThreshold,
	input wire logic [1:0] cableLinkDetected
);
	// =====================================================
	// shadow of the alias fields, one per port
	logic [6:0] alias0Q;
	logic [6:0] alias1Q;
	logic       rdSts;
	logic       hit0;
	logic       hit1;
	assign rdSts = regRdEn && regAddr == 8'h0C;
	assign hit0 = alias0Q != 7'h00 && addrIn == alias0Q;
	assign hit1 = alias1Q != 7'h00 && addrIn == alias1Q;
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			alias0Q <= 7'h00;
			alias1Q <= 7'h00;
		end else if (regWrEn && regAddr == 8'h08 && secondPortSelect) begin
			alias1Q <= regWrData[7:1];
		end else if (regWrEn && regAddr == 8'h08) begin
			alias0Q <= regWrData[7:1];
		end
	end
	default clocking @(posedge core_clk); endclocking
	default disable iff (rst);
	// =====================================================
	// properties
	property p_fwd0;
		addrValid && hit0 |=> fwdValid && !fwdPort1 && fwdAddr == $past(remoteTargetAddress);
	endproperty
	a_fwd0: assert property (p_fwd0) else $error("port0 forward wrong");
	property p_fwd1;
		addrValid && hit1 && !hit0 |=> fwdValid && fwdPort1
			&& fwdAddr == $past(remoteTargetAddressPort1);
	endproperty
	a_fwd1: assert property (p_fwd1) else $error("port1 forward wrong");
	property p_nofwd;
		addrValid && !hit0 && !hit1 |=> !fwdValid;
	endproperty
	a_nofwd: assert property (p_nofwd) else $error("forward without alias");
	property p_aliasrd;
		regRdEn && regAddr == 8'h08 && !regWrEn |=>
			regRdData == {($past(secondPortSelect) ? alias1Q : alias0Q), 1'b0};
	endproperty
	a_aliasrd: assert property (p_aliasrd) else $error("alias readback wrong");
	property p_hit;
		regRdEn |=> regHit == ($past(regAddr) >= 8'h08 && $past(regAddr) <= 8'h0C);
	endproperty
	a_hit: assert property (p_hit) else $error("hit flag wrong");
	property p_sdadrop;
		!(remoteAccess && ackSdaReq) |=> !ackSdaRelease;
	endproperty
	a_sdadrop: assert property (p_sdadrop) else $error("release without request");
	property p_sdaearly;
		$rose(remoteAccess && ackSdaReq) |=> !ackSdaRelease [*3];
	endproperty
	a_sdaearly: assert property (p_sdaearly) else $error("release too early");
	property p_dsi;
		$stable(dsiErrors)[*6] ##0 rdSts |=> regRdData[6] == $past(|dsiErrors);
	endproperty
	a_dsi: assert property (p_dsi) else $error("bit6 wrong");
	property p_lane;
		$stable({laneSyncError, laneFault})[*6] ##0 rdSts
			|=> regRdData[5] == $past(|{laneSyncError, laneFault});
	endproperty
	a_lane: assert property (p_lane) else $error("bit5 wrong");
	property p_lvl;
		$stable({secondPortSelect, pclkMeetsThreshold, cableLinkDetected})[*6] ##0 rdSts
			|=> regRdData[2] == $past(pclkMeetsThreshold[secondPortSelect])
			&& regRdData[0] == $past(cableLinkDetected[secondPortSelect]);
	endproperty
	a_lvl: assert property (p_lvl) else $error("bit2 or bit0 wrong");
	property p_rsvd;
		rdSts |=> !regRdData[7];
	endproperty
	a_rsvd: assert property (p_rsvd) else $error("bit7 set");
	c_fwd1: cover property (fwdValid && fwdPort1);
	c_rel: cover property ($rose(ackSdaRelease));
	c_miss: cover property (regRdEn ##1 !regHit);
endmodule
bind lasr_top lasr_properties i_props (.*);

// ==== sim/lasr_top_bench.sv ====
// self-checking bench for the link alias and status register bank
`timescale 1ns/100ps
`define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin bad_count++; \
	$display("wrong value %s expected %0h seen %0h", n, e, g); end end
module lasr_top_bench;
	import lasr_pkg::*;
	typedef struct packed {
		logic [4:0] dsi;
		logic [1:0] sync, fault, pclk, cable;
		logic sel;
		logic [7:0] sts;
	} lasr_row_t;
	lasr_row_t rows [4] = '{'{5'h10, 2'h0, 2'h0, 2'h1, 2'h1, 1'b0, 8'h45},
		'{5'h00, 2'h2, 2'h0, 2'h1, 2'h2, 1'b1, 8'h21},
		'{5'h01, 2'h0, 2'h1, 2'h2, 2'h3, 1'b1, 8'h65},
		'{5'h00, 2'h0, 2'h0, 2'h0, 2'h0, 1'b0, 8'h00}};
	logic [7:0] rstVals [7] = '{8'h00, 8'h00, 8'h01, 8'h00, 8'h00, 8'h00, 8'h00};
	logic core_clk, rst, regWrEn, regRdEn, regHit, secondPortSelect, crcErrorReset;
	logic addrValid, fwdValid, fwdPort1, remoteAccess, ackSdaReq, ackSdaRelease;
	logic goEvt, evtPort, hitSeen;
	logic [7:0] regAddr, regWrData, regRdData, rdData;
	logic [6:0] remoteTargetAddress, remoteTargetAddressPort1, addrIn, fwdAddr;
	logic [4:0] dsiErrors;
	logic [2:0] evtKind;
	logic [1:0] laneSyncError, laneFault, backCrcErr, linkLostEvt, selftestCrcErr;
	logic [1:0] selftestRestart, desCrcErr, pclkMeetsThreshold, cableLinkDetected;
	int bad_count, num_checks, cnt;
	lasr_top i_dut (.*);
	lasr_far_model i_far (.*);
	initial begin
		core_clk = 1'b0;
		forever #10 core_clk = ~core_clk;
	end
	task automatic tick(input int n);
		repeat (n) @(posedge core_clk);
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge core_clk);
		regWrEn <= 1'b1;
		regAddr <= a;
		regWrData <= d;
		@(posedge core_clk);
		regWrEn <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a);
		@(posedge core_clk);
		regRdEn <= 1'b1;
		regAddr <= a;
		@(posedge core_clk);
		regRdEn <= 1'b0;
		#1;
		rdData = regRdData;
		hitSeen = regHit;
	endtask
	task automatic fw(input logic [6:0] a, input logic v, input logic p, input logic [6:0] e);
		@(posedge core_clk);
		addrValid <= 1'b1;
		addrIn <= a;
		@(posedge core_clk);
		addrValid <= 1'b0;
		#1;
		`CHK("forward valid", v, fwdValid)
		if (v) begin
			`CHK("forward target", {p, e}, {fwdPort1, fwdAddr})
		end
	endtask
	task automatic evt(input logic [2:0] k);
		@(posedge core_clk);
		goEvt <= 1'b1;
		evtKind <= k;
		@(posedge core_clk);
		goEvt <= 1'b0;
		tick(9);
	endtask
	task automatic crcClear();
		crcErrorReset <= 1'b1;
		tick(5);
		crcErrorReset <= 1'b0;
		tick(5);
	endtask
	task automatic complete_run();
		$display("checks %0d mismatches %0d", num_checks, bad_count);
		if (bad_count == 0 && num_checks > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask
	initial begin
		{rst, regWrEn, regRdEn, secondPortSelect, crcErrorReset, addrValid} = 6'h20;
		{remoteAccess, ackSdaReq, goEvt, evtPort, evtKind, regAddr, regWrData} = '0;
		{addrIn, dsiErrors, laneSyncError, laneFault, pclkMeetsThreshold} = '0;
		cableLinkDetected = 2'h0;
		remoteTargetAddress = 7'h11;
		remoteTargetAddressPort1 = 7'h22;
		tick(10);
		rst <= 1'b0;
		// offsets 0x07 and 0x0D sit just outside the bank
		for (int i = 0; i < 7; i++) begin
			rd(8'h07 + 8'(i));
			`CHK("reset read", rstVals[i], rdData)
			`CHK("hit", (i inside {[1:5]}), hitSeen)
		end
		$display("reset test done");
		foreach (rows[i]) begin
			dsiErrors <= rows[i].dsi;
			laneSyncError <= rows[i].sync;
			laneFault <= rows[i].fault;
			pclkMeetsThreshold <= rows[i].pclk;
			cableLinkDetected <= rows[i].cable;
			secondPortSelect <= rows[i].sel;
			tick(6);
			rd(LASR_OFF_STATUS);
			`CHK("status row", rows[i].sts, rdData)
		end
		$display("status rows done");
		wr(LASR_OFF_ALIAS, 8'h51);
		secondPortSelect <= 1'b1;
		wr(LASR_OFF_ALIAS, 8'h60);
		rd(LASR_OFF_ALIAS);
		`CHK("alias port1", 8'h60, rdData)
		secondPortSelect <= 1'b0;
		rd(LASR_OFF_ALIAS);
		`CHK("alias port0", 8'h50, rdData)
		fw(7'h28, 1'b1, 1'b0, 7'h11);
		fw(7'h30, 1'b1, 1'b1, 7'h22);
		fw(7'h00, 1'b0, 1'b0, 7'h00);
		secondPortSelect <= 1'b1;
		wr(LASR_OFF_ALIAS, 8'h00);
		secondPortSelect <= 1'b0;
		fw(7'h30, 1'b0, 1'b0, 7'h00);
		$display("alias test done");
		wr(LASR_OFF_SETUP, 8'hF0);
		rd(LASR_OFF_SETUP);
		`CHK("setup field", 8'h00, rdData)
		for (int f = 0; f < 2; f++) begin
			wr(LASR_OFF_SETUP, 8'(f));
			remoteAccess <= 1'b1;
			ackSdaReq <= 1'b1;
			cnt = 0;
			while (ackSdaRelease !== 1'b1 && cnt < 200) begin
				@(posedge core_clk);
				#1;
				cnt++;
			end
			if (cnt >= 200) begin
				bad_count++;
				complete_run();
			end
			cnt = cnt - LASR_SETUP_BASE_CYC - LASR_SETUP_STEP_CYC * f;
			`CHK("setup delay", 1'b1, (cnt >= 0 && cnt <= 2))
			remoteAccess <= 1'b0;
			ackSdaReq <= 1'b0;
			tick(3);
		end
		$display("setup test done");
		wr(LASR_OFF_CRC_LOW, 8'hFF);
		repeat (3) evt(3'd0);
		rd(LASR_OFF_CRC_LOW);
		`CHK("crc low", 8'h03, rdData)
		rd(LASR_OFF_CRC_HIGH);
		`CHK("crc high", 8'h00, rdData)
		secondPortSelect <= 1'b1;
		rd(LASR_OFF_CRC_LOW);
		`CHK("crc port1", 8'h00, rdData)
		secondPortSelect <= 1'b0;
		crcClear();
		rd(LASR_OFF_CRC_LOW);
		`CHK("crc cleared", 8'h00, rdData)
		// model kinds: 0 back crc, 1 link lost, 2 des crc, 3 selftest crc, 4 restart
		evt(3'd2);
		rd(LASR_OFF_STATUS);
		`CHK("des error", 8'h02, rdData)
		evt(3'd1);
		rd(LASR_OFF_STATUS);
		`CHK("link lost", 8'h10, rdData)
		evt(3'd3);
		rd(LASR_OFF_STATUS);
		`CHK("selftest error", 8'h18, rdData)
		evt(3'd4);
		rd(LASR_OFF_STATUS);
		`CHK("selftest restart", 8'h10, rdData)
		secondPortSelect <= 1'b1;
		rd(LASR_OFF_STATUS);
		`CHK("status port1", 8'h00, rdData)
		secondPortSelect <= 1'b0;
		crcClear();
		rd(LASR_OFF_STATUS);
		`CHK("status cleared", 8'h00, rdData)
		$display("event test done");
		complete_run();
	end
endmodule
